// *** gpm_pkg.sv ***
// Shared constants, register map and carrier types for the port block
package gpm_pkg;

   // ===========================================================
   // Widths
   localparam int P5_W   = 8;
   localparam int P7_W   = 7;
   localparam int FSEL_W = 6;
   localparam int OSEL_W = 4;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ===========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_P5_DIR  = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_P5_DATA = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_P5_FSEL = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_P7_DIR  = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_P7_DATA = 12'h010;

   // ===========================================================
   // Pin positions
   localparam int P5_TX3_BIT  = 7;
   localparam int P5_RX3_BIT  = 6;
   localparam int P5_WAKEUP_IN5_BIT = 5;
   localparam int P7_TMO_BIT  = 6;
   localparam int P7_TCLK_BIT = 5;
   localparam int P7_TRST_BIT = 4;
   localparam int P7_TX2_BIT  = 2;
   localparam int P7_RX2_BIT  = 1;
   localparam int P7_RSVD_BIT = 7;

   // ===========================================================
   // Reset and fixed values
   localparam logic [P5_W-1:0]   P5_DIR_RST  = 8'h00;
   localparam logic [P5_W-1:0]   P5_DATA_RST = 8'h00;
   localparam logic [FSEL_W-1:0] P5_FSEL_RST = 6'h00;
   localparam logic [P7_W-1:0]   P7_DIR_RST  = 7'h00;
   localparam logic [P7_W-1:0]   P7_DATA_RST = 7'h00;
   localparam logic              P7_RSVD_RD  = 1'h1;
   localparam logic [OSEL_W-1:0] OSEL_OFF    = 4'h0;
   localparam logic              IDLE_HIGH   = 1'h1;

   // ===========================================================
   // Carriers
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } gpm_apb_req_t;

   typedef struct packed {
      logic              s3_tx_sel;
      logic              s3_txd;
      logic              s3_rx_on;
      logic              s2_tx_sel;
      logic              s2_txd;
      logic              s2_rx_on;
      logic [OSEL_W-1:0] tmr_osel;
      logic              tmr_out;
   } gpm_periph_in_t;

   typedef struct packed {
      logic              s3_rxd;
      logic              s2_rxd;
      logic [FSEL_W-1:0] wakeup_n;
      logic              trig_n;
      logic              tmr_clk_in;
      logic              tmr_rst_in;
   } gpm_periph_out_t;

   typedef struct packed {
      logic [P5_W-1:0]   p5_dir;
      logic [P5_W-1:0]   p5_data;
      logic [FSEL_W-1:0] p5_fsel;
      logic [P7_W-1:0]   p7_dir;
      logic [P7_W-1:0]   p7_data;
      logic [DATA_W-1:0] prdata;
      logic              pslverr;
      gpm_periph_out_t   pout;
   } gpm_state_t;

endpackage

// *** gpm_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gpm_sync #(
   parameter int WIDTH  = 8,
   parameter int STAGES = 2
) (
   input  wire logic             clock_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   // ===========================================================
   // Parameter check
   if (WIDTH < 1 || STAGES < 2) begin : g_bad
      $error("gpm_sync: needs WIDTH >= 1 and STAGES >= 2");
   end

   // ===========================================================
   // Shift chain; first stage feeds only the next stage
   logic [STAGES-1:0][WIDTH-1:0] chain_r;
   logic [STAGES-1:0][WIDTH-1:0] chain_nxt;

   always_comb begin
      chain_nxt = {chain_r[STAGES-2:0], async_i};
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chain_r <= '0;
      end else begin
         chain_r <= chain_nxt;
      end
   end

   assign sync_o = chain_r[STAGES-1];

endmodule

// *** gpm_pin_mux.sv ***
// Per-pin drive selection between port register and a peripheral
`timescale 1ns/1ps
module gpm_pin_mux #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] dir_i,
   input  wire logic [WIDTH-1:0] data_i,
   input  wire logic [WIDTH-1:0] claim_out_i,
   input  wire logic [WIDTH-1:0] claim_in_i,
   input  wire logic [WIDTH-1:0] alt_out_i,
   output logic      [WIDTH-1:0] oe_o,
   output logic      [WIDTH-1:0] out_o
);

   // ===========================================================
   // Parameter check
   if (WIDTH < 1) begin : g_bad
      $error("gpm_pin_mux: WIDTH must be at least 1");
   end

   // ===========================================================
   // A claimed output wins; a claimed input forces the driver off
   assign oe_o  = claim_out_i | (dir_i & ~claim_in_i);
   assign out_o = (claim_out_i & alt_out_i) | (~claim_out_i & data_i);

endmodule

// *** gpm_top.sv ***
// Port 5 and port 7 general I/O with peripheral pin multiplexing
//
// Summary of operation
// - Unclaimed pin: direction 0 is input, 1 is output.
// - Serial3 transmit select drives port5 bit7 with serial3 data.
// - Serial3 receive enable makes port5 bit6 its receive input.
// - Port5 bit5 wakeup select makes it wakeup and trigger input.
// - Port5 bits 4..0 wakeup select make each a wakeup input.
// - Nonzero timer output select makes port7 bit6 the timer output.
// - Port7 bits 5 and 4 always feed timer clock and reset.
// - Port7 direction bit 1 is output, 0 is input; bit7 reserved.
// - Port7 direction is per bit, write-only, resets to all inputs.
// - Port7 data holds drive values; bits 6..0 reset to zero.
// - Port7 data read returns stored bit where direction is 1.
// - Port7 data read returns live pin where direction is 0.
// - Port7 data bit7 always reads as 1.
// - Serial2 transmit select drives port7 bit2 with serial2 data.
// - Serial2 receive enable makes port7 bit1 its receive input.
// - Port5 direction is write-only, 1 output, resets to zero.
// - Port5 function select resets to zero; 1 picks wakeup input.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module gpm_top (
   input  wire logic                         clock_i,
   input  wire logic                         resetn_i,
   input  wire gpm_pkg::gpm_apb_req_t        apb_i,
   output logic      [gpm_pkg::DATA_W-1:0]   prdata_o,
   output logic                              pready_o,
   output logic                              pslverr_o,
   input  wire logic [gpm_pkg::P5_W-1:0]     p5_in_i,
   output logic      [gpm_pkg::P5_W-1:0]     p5_out_o,
   output logic      [gpm_pkg::P5_W-1:0]     p5_oe_o,
   input  wire logic [gpm_pkg::P7_W-1:0]     p7_in_i,
   output logic      [gpm_pkg::P7_W-1:0]     p7_out_o,
   output logic      [gpm_pkg::P7_W-1:0]     p7_oe_o,
   input  wire gpm_pkg::gpm_periph_in_t      periph_i,
   output gpm_pkg::gpm_periph_out_t          periph_o
);

   localparam int P5W = gpm_pkg::P5_W;
   localparam int P7W = gpm_pkg::P7_W;
   localparam int SW  = P5W + P7W;

   // ===========================================================
   // Helpers
   function automatic logic [P5W-1:0] rd_mix(
      input logic [P5W-1:0] dir,
      input logic [P5W-1:0] data,
      input logic [P5W-1:0] pin
   );
      rd_mix = (dir & data) | (~dir & pin);
   endfunction

   function automatic logic is_mapped(
      input logic [gpm_pkg::ADDR_W-1:0] addr
   );
      is_mapped = (addr == gpm_pkg::OFS_P5_DIR)  ||
                  (addr == gpm_pkg::OFS_P5_DATA) ||
                  (addr == gpm_pkg::OFS_P5_FSEL) ||
                  (addr == gpm_pkg::OFS_P7_DIR)  ||
                  (addr == gpm_pkg::OFS_P7_DATA);
   endfunction

   // ===========================================================
   // Pin synchronisers
   logic [SW-1:0]  pins_sync;
   logic [P5W-1:0] p5_pin;
   logic [P7W-1:0] p7_pin;

   gpm_sync #(
      .WIDTH  (SW),
      .STAGES (2)
   ) u_sync (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .async_i  ({p7_in_i, p5_in_i}),
      .sync_o   (pins_sync)
   );

   assign p5_pin = pins_sync[P5W-1:0];
   assign p7_pin = pins_sync[SW-1:P5W];

   // ===========================================================
   // State
   gpm_pkg::gpm_state_t st_r;
   gpm_pkg::gpm_state_t st_nxt;
   logic                setup_s;
   logic                access_s;

   assign setup_s  = apb_i.psel & ~apb_i.penable;
   assign access_s = apb_i.psel & apb_i.penable;

   always_comb begin
      st_nxt = st_r;
      // Register writes commit at the access edge only
      if (access_s && apb_i.pwrite) begin
         unique case (apb_i.paddr)
            gpm_pkg::OFS_P5_DIR:  st_nxt.p5_dir  = apb_i.pwdata[P5W-1:0];
            gpm_pkg::OFS_P5_DATA: st_nxt.p5_data = apb_i.pwdata[P5W-1:0];
            gpm_pkg::OFS_P5_FSEL: st_nxt.p5_fsel =
               apb_i.pwdata[gpm_pkg::FSEL_W-1:0];
            gpm_pkg::OFS_P7_DIR:  st_nxt.p7_dir  = apb_i.pwdata[P7W-1:0];
            gpm_pkg::OFS_P7_DATA: st_nxt.p7_data = apb_i.pwdata[P7W-1:0];
            default: ;
         endcase
      end
      // Read data captured in setup so it comes from a flop in access
      if (setup_s) begin
         st_nxt.prdata  = '0;
         st_nxt.pslverr = ~is_mapped(apb_i.paddr);
         if (!apb_i.pwrite) begin
            unique case (apb_i.paddr)
               gpm_pkg::OFS_P5_DATA: st_nxt.prdata[P5W-1:0] =
                  rd_mix(st_r.p5_dir, st_r.p5_data, p5_pin);
               gpm_pkg::OFS_P5_FSEL: st_nxt.prdata[gpm_pkg::FSEL_W-1:0] =
                  st_r.p5_fsel;
               gpm_pkg::OFS_P7_DATA: begin
                  st_nxt.prdata[P5W-1:0] = rd_mix({1'b0, st_r.p7_dir},
                     {1'b0, st_r.p7_data}, {1'b0, p7_pin});
                  st_nxt.prdata[gpm_pkg::P7_RSVD_BIT] =
                     gpm_pkg::P7_RSVD_RD;
               end
               // Direction registers are write-only and read as zero
               default: ;
            endcase
         end
      end
      // Peripheral inputs; wakeup lines idle high when not selected
      st_nxt.pout.s3_rxd = periph_i.s3_rx_on ?
         p5_pin[gpm_pkg::P5_RX3_BIT] : gpm_pkg::IDLE_HIGH;
      st_nxt.pout.s2_rxd = periph_i.s2_rx_on ?
         p7_pin[gpm_pkg::P7_RX2_BIT] : gpm_pkg::IDLE_HIGH;
      st_nxt.pout.wakeup_n = p5_pin[gpm_pkg::FSEL_W-1:0] |
         ~st_r.p5_fsel;
      st_nxt.pout.trig_n = st_r.p5_fsel[gpm_pkg::P5_WAKEUP_IN5_BIT] ?
         p5_pin[gpm_pkg::P5_WAKEUP_IN5_BIT] : gpm_pkg::IDLE_HIGH;
      st_nxt.pout.tmr_clk_in = p7_pin[gpm_pkg::P7_TCLK_BIT];
      st_nxt.pout.tmr_rst_in = p7_pin[gpm_pkg::P7_TRST_BIT];
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r.p5_dir  <= gpm_pkg::P5_DIR_RST;
         st_r.p5_data <= gpm_pkg::P5_DATA_RST;
         st_r.p5_fsel <= gpm_pkg::P5_FSEL_RST;
         st_r.p7_dir  <= gpm_pkg::P7_DIR_RST;
         st_r.p7_data <= gpm_pkg::P7_DATA_RST;
         st_r.prdata  <= '0;
         st_r.pslverr <= 1'b0;
         st_r.pout    <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ===========================================================
   // Bus answer: zero wait states
   assign pready_o  = 1'b1;
   assign prdata_o  = st_r.prdata;
   assign pslverr_o = st_r.pslverr & access_s;
   assign periph_o  = st_r.pout;

   // ===========================================================
   // Pin claims
   logic [P5W-1:0] p5_claim_out;
   logic [P5W-1:0] p5_claim_in;
   logic [P5W-1:0] p5_alt;
   logic [P7W-1:0] p7_claim_out;
   logic [P7W-1:0] p7_claim_in;
   logic [P7W-1:0] p7_alt;

   always_comb begin
      p5_claim_out = '0;
      p5_alt       = '0;
      p5_claim_in  = '0;
      p5_claim_out[gpm_pkg::P5_TX3_BIT] = periph_i.s3_tx_sel;
      p5_alt[gpm_pkg::P5_TX3_BIT]       = periph_i.s3_txd;
      p5_claim_in[gpm_pkg::P5_RX3_BIT]  = periph_i.s3_rx_on;
      // Wakeup selects cover bits 5..0, bit5 doubling as trigger
      p5_claim_in[gpm_pkg::FSEL_W-1:0]  = st_r.p5_fsel;
      p7_claim_out = '0;
      p7_alt       = '0;
      p7_claim_in  = '0;
      p7_claim_out[gpm_pkg::P7_TMO_BIT] =
         (periph_i.tmr_osel != gpm_pkg::OSEL_OFF);
      p7_alt[gpm_pkg::P7_TMO_BIT]       = periph_i.tmr_out;
      p7_claim_out[gpm_pkg::P7_TX2_BIT] = periph_i.s2_tx_sel;
      p7_alt[gpm_pkg::P7_TX2_BIT]       = periph_i.s2_txd;
      p7_claim_in[gpm_pkg::P7_RX2_BIT]  = periph_i.s2_rx_on;
   end

   gpm_pin_mux #(
      .WIDTH (P5W)
   ) u_mux5 (
      .dir_i       (st_r.p5_dir),
      .data_i      (st_r.p5_data),
      .claim_out_i (p5_claim_out),
      .claim_in_i  (p5_claim_in),
      .alt_out_i   (p5_alt),
      .oe_o        (p5_oe_o),
      .out_o       (p5_out_o)
   );

   gpm_pin_mux #(
      .WIDTH (P7W)
   ) u_mux7 (
      .dir_i       (st_r.p7_dir),
      .data_i      (st_r.p7_data),
      .claim_out_i (p7_claim_out),
      .claim_in_i  (p7_claim_in),
      .alt_out_i   (p7_alt),
      .oe_o        (p7_oe_o),
      .out_o       (p7_out_o)
   );

   // ===========================================================
   // Assertions
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   sequence p7_data_wr_s;
      access_s && apb_i.pwrite && apb_i.paddr == gpm_pkg::OFS_P7_DATA;
   endsequence

   sequence p7_data_rd_s;
      setup_s && !apb_i.pwrite && apb_i.paddr == gpm_pkg::OFS_P7_DATA;
   endsequence

   sequence tclk_steady_s;
      $stable(p7_in_i[gpm_pkg::P7_TCLK_BIT]) [*3];
   endsequence

   sequence trst_steady_s;
      $stable(p7_in_i[gpm_pkg::P7_TRST_BIT]) [*3];
   endsequence

   sequence p5_fsel_wr_s;
      access_s && apb_i.pwrite && apb_i.paddr == gpm_pkg::OFS_P5_FSEL;
   endsequence

   // Both direction registers are write-only
   sequence dir_rd_s;
      setup_s && !apb_i.pwrite && (apb_i.paddr == gpm_pkg::OFS_P7_DIR ||
      apb_i.paddr == gpm_pkg::OFS_P5_DIR);
   endsequence

   plain_dir_a: assert property (
      p7_oe_o[3] == st_r.p7_dir[3] && p5_out_o[0] == st_r.p5_data[0])
      else $error("plain pin direction mismatch");

   s3_tx_a: assert property (periph_i.s3_tx_sel |->
      p5_oe_o[gpm_pkg::P5_TX3_BIT] &&
      p5_out_o[gpm_pkg::P5_TX3_BIT] == periph_i.s3_txd)
      else $error("serial3 transmit pin not driven");

   s3_rx_a: assert property (periph_i.s3_rx_on |->
      !p5_oe_o[gpm_pkg::P5_RX3_BIT])
      else $error("serial3 receive pin driven");

   wkp_pins_a: assert property (
      (p5_oe_o[gpm_pkg::FSEL_W-1:0] & st_r.p5_fsel) == '0)
      else $error("wakeup pin driven");

   tmr_out_a: assert property (
      periph_i.tmr_osel != gpm_pkg::OSEL_OFF |->
      p7_oe_o[gpm_pkg::P7_TMO_BIT] &&
      p7_out_o[gpm_pkg::P7_TMO_BIT] == periph_i.tmr_out)
      else $error("timer output pin not driven");

   tmr_clk_a: assert property (tclk_steady_s |=>
      periph_o.tmr_clk_in == $past(p7_in_i[gpm_pkg::P7_TCLK_BIT]))
      else $error("timer clock input not following pin");

   p7_write_a: assert property (p7_data_wr_s |=>
      st_r.p7_data == $past(apb_i.pwdata[P7W-1:0]))
      else $error("port7 data write lost");

   p7_read_a: assert property (p7_data_rd_s |=>
      prdata_o[gpm_pkg::P7_RSVD_BIT] && prdata_o[31:8] == '0 &&
      prdata_o[P7W-1:0] == (($past(st_r.p7_dir) & $past(st_r.p7_data)) |
      (~$past(st_r.p7_dir) & $past(p7_pin))))
      else $error("port7 data read value wrong");

   s2_tx_a: assert property (periph_i.s2_tx_sel |->
      p7_oe_o[gpm_pkg::P7_TX2_BIT] &&
      p7_out_o[gpm_pkg::P7_TX2_BIT] == periph_i.s2_txd)
      else $error("serial2 transmit pin not driven");

   s2_rx_a: assert property (periph_i.s2_rx_on |->
      !p7_oe_o[gpm_pkg::P7_RX2_BIT])
      else $error("serial2 receive pin driven");

   tmr_rst_a: assert property (trst_steady_s |=>
      periph_o.tmr_rst_in == $past(p7_in_i[gpm_pkg::P7_TRST_BIT]))
      else $error("timer reset input not following pin");

   s3_rxd_a: assert property (periph_i.s3_rx_on |=>
      periph_o.s3_rxd == $past(p5_pin[gpm_pkg::P5_RX3_BIT]))
      else $error("serial3 receive data not following pin");

   s2_rxd_a: assert property (periph_i.s2_rx_on |=>
      periph_o.s2_rxd == $past(p7_pin[gpm_pkg::P7_RX2_BIT]))
      else $error("serial2 receive data not following pin");

   trig_in_a: assert property (
      st_r.p5_fsel[gpm_pkg::P5_WAKEUP_IN5_BIT] |=>
      periph_o.trig_n == $past(p5_pin[gpm_pkg::P5_WAKEUP_IN5_BIT]) &&
      periph_o.wakeup_n[gpm_pkg::P5_WAKEUP_IN5_BIT] == periph_o.trig_n)
      else $error("trigger input not following wakeup pin");

   wkp_idle_a: assert property (!st_r.p5_fsel[0] |=>
      periph_o.wakeup_n[0])
      else $error("unselected wakeup line not idle");

   fsel_write_a: assert property (p5_fsel_wr_s |=>
      st_r.p5_fsel == $past(apb_i.pwdata[gpm_pkg::FSEL_W-1:0]))
      else $error("port5 function select write lost");

   dir_read_a: assert property (dir_rd_s |=> prdata_o == '0)
      else $error("direction register read not zero");

endmodule

// *** gpm_pin_model.sv ***
// Pin-level model of the boards wired to ports 5 and 7
`timescale 1ns/1ps
module gpm_pin_model (
   input  wire logic [gpm_pkg::P5_W-1:0] p5_out_i,
   input  wire logic [gpm_pkg::P5_W-1:0] p5_oe_i,
   input  wire logic [gpm_pkg::P5_W-1:0] ext5_i,
   input  wire logic [gpm_pkg::P7_W-1:0] p7_out_i,
   input  wire logic [gpm_pkg::P7_W-1:0] p7_oe_i,
   input  wire logic [gpm_pkg::P7_W-1:0] ext7_i,
   output logic      [gpm_pkg::P5_W-1:0] p5_pin_o,
   output logic      [gpm_pkg::P7_W-1:0] p7_pin_o
);
   // =========================================================
   // Wire resolution
   // Device drive wins, so an output pin reads back its own value
   assign p5_pin_o = (p5_oe_i & p5_out_i) | (~p5_oe_i & ext5_i);
   assign p7_pin_o = (p7_oe_i & p7_out_i) | (~p7_oe_i & ext7_i);
endmodule

// *** gpm_top_tb.sv ***
// Self-checking testbench for the port 5 / port 7 block
`timescale 1ns/1ps
module gpm_top_tb;
   // =========================================================
   // Signals
   logic                     clock_i;
   logic                     resetn_i;
   gpm_pkg::gpm_apb_req_t    apb;
   logic [31:0]              prdata;
   logic                     pready;
   logic                     pslverr;
   logic [7:0]               p5_pin;
   logic [7:0]               p5_out;
   logic [7:0]               p5_oe;
   logic [7:0]               ext5;
   logic [6:0]               p7_pin;
   logic [6:0]               p7_out;
   logic [6:0]               p7_oe;
   logic [6:0]               ext7;
   gpm_pkg::gpm_periph_in_t  periph;
   gpm_pkg::gpm_periph_out_t pout;
   int                       error_cnt;
   int                       samples_checked;

   // =========================================================
   // Instances
   gpm_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .apb_i(apb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .p5_in_i(p5_pin), .p5_out_o(p5_out), .p5_oe_o(p5_oe),
      .p7_in_i(p7_pin), .p7_out_o(p7_out), .p7_oe_o(p7_oe),
      .periph_i(periph), .periph_o(pout));
   gpm_pin_model pins_u (.p5_out_i(p5_out), .p5_oe_i(p5_oe),
      .ext5_i(ext5), .p7_out_i(p7_out), .p7_oe_i(p7_oe),
      .ext7_i(ext7), .p5_pin_o(p5_pin), .p7_pin_o(p7_pin));

   // =========================================================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic apb_xfer(input logic wr, input logic [11:0] adr,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge clock_i);
      apb.psel    <= 1'b1;
      apb.penable <= 1'b0;
      apb.pwrite  <= wr;
      apb.paddr   <= adr;
      apb.pwdata  <= wd;
      @(posedge clock_i);
      apb.penable <= 1'b1;
      // The wait for the answer ends once pready is 1; the watchdog ends it if pready never rises
      do begin
         @(posedge clock_i);
      end while (pready !== 1'b1);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      apb.psel    <= 1'b0;
      apb.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
      logic [31:0] r;
      logic        e;
      apb_xfer(1'b1, adr, wd, r, e);
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] adr,
                         input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb_xfer(1'b0, adr, 32'h0, r, e);
      chk(nm, exp, r);
      chk("pslverr", {31'h0, exp_err}, {31'h0, e});
   endtask

   // Pin paths pass two sync flops and a register
   task automatic settle();
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
   endtask

   // =========================================================
   // Scenarios
   task automatic t_reset();
      settle();
      chk("p5_oe", 32'h0, {24'h0, p5_oe});
      chk("p7_oe", 32'h0, {25'h0, p7_oe});
      chk("wakeup_n", 32'h3F, {26'h0, pout.wakeup_n});
      rd_chk("p7 data", gpm_pkg::OFS_P7_DATA, 32'h80, 1'b0);
      rd_chk("p5 fsel", gpm_pkg::OFS_P5_FSEL, 32'h0, 1'b0);
      rd_chk("unmapped", 12'h014, 32'h0, 1'b1);
   endtask

   task automatic t_port7();
      wr(gpm_pkg::OFS_P7_DIR, 32'h8F);
      wr(gpm_pkg::OFS_P7_DATA, 32'h55);
      @(negedge clock_i);
      chk("p7_oe", 32'h0F, {25'h0, p7_oe});
      chk("p7_out", 32'h05, {25'h0, p7_out & p7_oe});
      rd_chk("p7 dir", gpm_pkg::OFS_P7_DIR, 32'h0, 1'b0);
      // Serial2 pulls bit2 low, so only a stored read gives 1 there
      @(posedge clock_i);
      ext7             <= 7'h2A;
      periph.s2_tx_sel <= 1'b1;
      periph.s2_txd    <= 1'b0;
      settle();
      rd_chk("p7 mixed", gpm_pkg::OFS_P7_DATA, 32'hA5, 1'b0);
   endtask

   task automatic t_timer();
      @(posedge clock_i);
      ext7 <= 7'h20;
      settle();
      chk("tmr clk", 32'h1, {31'h0, pout.tmr_clk_in});
      chk("tmr rst", 32'h0, {31'h0, pout.tmr_rst_in});
      wr(gpm_pkg::OFS_P7_DIR, 32'h30);
      settle();
      chk("tmr clk out", 32'h0, {31'h0, pout.tmr_clk_in});
      chk("tmr rst out", 32'h1, {31'h0, pout.tmr_rst_in});
      for (int s = 0; s < 16; s++) begin
         @(posedge clock_i);
         periph.tmr_osel <= 4'(s);
         periph.tmr_out  <= s[0];
         @(negedge clock_i);
         chk("p7_oe6", {31'h0, s != 0}, {31'h0, p7_oe[6]});
         if (s != 0)
            chk("p7_out6", {31'h0, s[0]}, {31'h0, p7_out[6]});
      end
   endtask

   task automatic t_serial2();
      for (int v = 0; v < 2; v++) begin
         @(posedge clock_i);
         periph.s2_tx_sel <= 1'b1;
         periph.s2_txd    <= v[0];
         @(negedge clock_i);
         chk("p7_oe2", 32'h1, {31'h0, p7_oe[2]});
         chk("p7_out2", {31'h0, v[0]}, {31'h0, p7_out[2]});
      end
      wr(gpm_pkg::OFS_P7_DIR, 32'h32);
      @(posedge clock_i);
      periph.s2_rx_on <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         @(posedge clock_i);
         ext7 <= {5'h00, v[0], 1'b0};
         settle();
         chk("p7_oe1", 32'h0, {31'h0, p7_oe[1]});
         chk("s2_rxd", {31'h0, v[0]}, {31'h0, pout.s2_rxd});
      end
   endtask

   task automatic t_port5();
      logic [7:0] e;
      wr(gpm_pkg::OFS_P5_DIR, 32'hFF);
      wr(gpm_pkg::OFS_P5_DATA, 32'hA5);
      @(negedge clock_i);
      chk("p5_oe", 32'hFF, {24'h0, p5_oe});
      chk("p5_out", 32'hA5, {24'h0, p5_out});
      rd_chk("p5 data", gpm_pkg::OFS_P5_DATA, 32'hA5, 1'b0);
      @(posedge clock_i);
      periph.s3_tx_sel <= 1'b1;
      periph.s3_txd    <= 1'b0;
      periph.s3_rx_on  <= 1'b1;
      wr(gpm_pkg::OFS_P5_FSEL, 32'h3F);
      for (int k = 0; k < 2; k++) begin
         e = k ? 8'h15 : 8'h6A;
         @(posedge clock_i);
         ext5 <= e;
         settle();
         chk("p5_oe", 32'h80, {24'h0, p5_oe});
         chk("p5_out7", 32'h0, {31'h0, p5_out[7]});
         chk("s3_rxd", {31'h0, e[6]}, {31'h0, pout.s3_rxd});
         chk("trig_n", {31'h0, e[5]}, {31'h0, pout.trig_n});
         chk("wakeup_n", {26'h0, e[5:0]}, {26'h0, pout.wakeup_n});
      end
   endtask

   // Data register reset is only visible with every pin an output
   task automatic t_rst_mid();
      @(posedge clock_i);
      periph   <= '0;
      resetn_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(negedge clock_i);
      chk("p5_oe", 32'h0, {24'h0, p5_oe});
      chk("p7_oe", 32'h0, {25'h0, p7_oe});
      rd_chk("p5 fsel", gpm_pkg::OFS_P5_FSEL, 32'h0, 1'b0);
      wr(gpm_pkg::OFS_P7_DIR, 32'h7F);
      rd_chk("p7 data", gpm_pkg::OFS_P7_DATA, 32'h80, 1'b0);
   endtask

   // =========================================================
   // Run control
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   initial begin
      #100000;
      error_cnt++;
      $display("[FAIL] watchdog expected done seen hang");
      finish_test();
   end

   initial begin
      error_cnt       = 0;
      samples_checked = 0;
      resetn_i        = 1'b0;
      apb             = '0;
      periph          = '0;
      ext5            = 8'h00;
      ext7            = 7'h00;
      repeat (10) @(posedge clock_i);
      resetn_i <= 1'b1;
      t_reset();
      t_port7();
      t_timer();
      t_serial2();
      t_port5();
      t_rst_mid();
      finish_test();
   end
endmodule
